// file: inc/sadc_pkg.sv
// ****************************************
// sadc package
// ****************************************
package sadc_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int RES_W      = 16;
  localparam int FIFO_DEPTH = 8;

  // ****************************************
  // timing
  // ****************************************
  localparam int CORE_CLK_NS    = 10;
  localparam int INT_CLK_NS     = 125;
  localparam int T_CONV_MIN_NS  = 500;
  localparam int T_CONV_MAX_NS  = 710;
  // device conversion length, whole timebase cycles, rounded up
  localparam int CONV_CYC       = (T_CONV_MIN_NS + INT_CLK_NS - 1) / INT_CLK_NS;
  // falling edges from a select change to the first driven bit
  localparam int SYNC_LAT       = 3;
  localparam int SCLK_HALF      = 4;
  localparam int SCLK_NS        = 2 * SCLK_HALF * CORE_CLK_NS;
  // host waits out the longest conversion plus the device's input sync
  localparam int CONV_WAIT_TICKS = (T_CONV_MAX_NS + SCLK_NS - 1) / SCLK_NS + SYNC_LAT;
  localparam int GAP_TICKS      = 2;

  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [1:0] {
    SADC_M_3W    = 2'b00,
    SADC_M_4W    = 2'b01,
    SADC_M_DAISY = 2'b10
  } sadc_mode_t;

  typedef enum logic [1:0] {
    SADC_D_IDLE  = 2'b00,
    SADC_D_ACQ   = 2'b01,
    SADC_D_CONV  = 2'b10,
    SADC_D_SHIFT = 2'b11
  } sadc_dev_st_t;

  typedef enum logic [2:0] {
    SADC_H_IDLE = 3'b000,
    SADC_H_ARM  = 3'b001,
    SADC_H_CONV = 3'b010,
    SADC_H_LAT  = 3'b011,
    SADC_H_READ = 3'b100,
    SADC_H_GAP  = 3'b101
  } sadc_host_st_t;

endpackage

// file: inc/sadc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sadc_link_if;
  logic link_clk;
  logic convert_start_in;
  logic serial_in;
  logic dout;
  logic dout_oe;
  logic dout_line;

  // floating output modelled as a weak high
  assign dout_line = dout_oe ? dout : 1'b1;

  modport dev (
    input  link_clk,
    input  convert_start_in,
    input  serial_in,
    output dout,
    output dout_oe
  );

  modport host (
    output link_clk,
    output convert_start_in,
    output serial_in,
    input  dout_line
  );
endinterface
`default_nettype wire

// file: hw/sadc_dev_end.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_dev_end #(
  parameter int RES_W    = sadc_pkg::RES_W,
  parameter int CONV_CYC = sadc_pkg::CONV_CYC
) (
  sadc_link_if.dev                       link,
  input  wire logic                      link_rstn,
  input  wire logic signed [RES_W-1:0]   positive_analog_input,
  input  wire logic signed [RES_W-1:0]   negative_analog_input,
  output logic                           inputs_isolated,
  output logic                           core_active,
  output logic [RES_W-1:0]               last_result
);

  localparam int CW = $clog2(RES_W) + 1;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    sadc_pkg::sadc_dev_st_t st;
    logic [1:0]             cs_sync;
    logic [1:0]             din_sync;
    logic                   cs_prev;
    logic                   daisy;
    logic [CW-1:0]          cnt;
    logic [RES_W-1:0]       held;
    logic [RES_W-1:0]       shreg;
    logic [RES_W-1:0]       last;
    logic                   dout;
    logic                   dout_oe;
    logic                   isolated;
    logic                   active;
  } sadc_dev_s_t;

  sadc_dev_s_t r_reg;
  sadc_dev_s_t r_next;

  logic                   cs;
  logic                   din;
  logic                   rise;
  logic                   sel;
  logic signed [RES_W:0]  diff;
  logic [RES_W-1:0]       sample;

  // ****************************************
  // decode
  // ****************************************
  assign cs   = r_reg.cs_sync[1];
  assign din  = r_reg.din_sync[1];
  assign rise = cs & ~r_reg.cs_prev;

  // three-wire: din tied high, start line low selects; four-wire:
  // start line held high, din low selects; daisy: start line low
  assign sel = r_reg.daisy ? ~cs : ~(cs & din);

  // differential span is twice either input's, so keep the upper bits
  assign diff   = {positive_analog_input[RES_W-1], positive_analog_input}
                - {negative_analog_input[RES_W-1], negative_analog_input};
  assign sample = diff[RES_W:1];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    r_next          = r_reg;
    r_next.cs_sync  = {r_reg.cs_sync[0], link.convert_start_in};
    r_next.din_sync = {r_reg.din_sync[0], link.serial_in};
    r_next.cs_prev  = cs;

    if (rise) begin
      r_next.dout_oe  = 1'b0;
      r_next.daisy    = ~din;
      r_next.held     = sample;
      r_next.isolated = 1'b1;
      r_next.active   = 1'b1;
      r_next.cnt      = CW'(CONV_CYC - 1);
      r_next.st       = sadc_pkg::SADC_D_CONV;
    end else begin
      case (r_reg.st)
        sadc_pkg::SADC_D_CONV: begin
          // counts down on link_clk falls; only a new start edge breaks in, select pins unused until the end
          if (r_reg.cnt == '0) begin
            r_next.isolated = 1'b0;
            r_next.active   = 1'b0;
            r_next.shreg    = r_reg.held;
            r_next.last     = r_reg.held;
            r_next.st       = sadc_pkg::SADC_D_ACQ;
            if (sel) begin
              // still selected at the end: announce with a busy bit
              r_next.dout    = 1'b1;
              r_next.dout_oe = 1'b1;
            end
          end else begin
            r_next.cnt = r_reg.cnt - 1'b1;
          end
        end
        sadc_pkg::SADC_D_ACQ: begin
          if (sel) begin
            r_next.dout    = r_reg.shreg[RES_W-1];
            r_next.dout_oe = 1'b1;
            r_next.shreg   = {r_reg.shreg[RES_W-2:0], din};
            r_next.cnt     = CW'(RES_W - 1);
            r_next.st      = sadc_pkg::SADC_D_SHIFT;
          end else begin
            r_next.dout_oe = 1'b0;
          end
        end
        sadc_pkg::SADC_D_SHIFT: begin
          if (r_reg.daisy) begin
            // chain mode keeps passing upstream bits while selected
            if (sel) begin
              r_next.dout  = r_reg.shreg[RES_W-1];
              r_next.shreg = {r_reg.shreg[RES_W-2:0], din};
            end else begin
              r_next.dout_oe = 1'b0;
              r_next.st      = sadc_pkg::SADC_D_IDLE;
            end
          end else if (!sel || r_reg.cnt == '0) begin
            // deselect mid-word abandons the rest of the result
            r_next.dout_oe = 1'b0;
            r_next.st      = sadc_pkg::SADC_D_IDLE;
          end else begin
            r_next.dout  = r_reg.shreg[RES_W-1];
            r_next.shreg = {r_reg.shreg[RES_W-2:0], 1'b0};
            r_next.cnt   = r_reg.cnt - 1'b1;
          end
        end
        default: begin
          r_next.dout_oe = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // outputs change on the falling edge so the host samples on the rising one
  always_ff @(negedge link.link_clk) begin
    if (!link_rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.dout       = r_reg.dout;
  assign link.dout_oe    = r_reg.dout_oe;
  assign inputs_isolated = r_reg.isolated;
  assign core_active     = r_reg.active;
  assign last_result     = r_reg.last;

endmodule
`default_nettype wire

// file: hw/sadc_host_end.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_fifo #(
  parameter int W     = sadc_pkg::RES_W,
  parameter int DEPTH = sadc_pkg::FIFO_DEPTH
) (
  input  wire logic          core_clk,
  input  wire logic          rstn,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data
);

  localparam int AW = $clog2(DEPTH);

  // depth must be a power of two so pointers wrap by themselves
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             count;
    logic                    valid;
    logic [W-1:0]            head;
  } sadc_fifo_s_t;

  sadc_fifo_s_t r_reg;
  sadc_fifo_s_t r_next;
  logic         do_wr;
  logic         do_rd;

  assign in_ready  = r_reg.count != (AW+1)'(DEPTH);
  assign out_valid = r_reg.valid;
  assign out_data  = r_reg.head;
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always_comb begin
    r_next = r_reg;
    if (do_wr) begin
      r_next.mem[r_reg.wp] = in_data;
      r_next.wp            = r_reg.wp + 1'b1;
    end
    if (do_rd) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
    case ({do_wr, do_rd})
      2'b10:   r_next.count = r_reg.count + 1'b1;
      2'b01:   r_next.count = r_reg.count - 1'b1;
      default: r_next.count = r_reg.count;
    endcase
    // head and valid registered so the result port comes straight from flops
    r_next.valid = r_next.count != '0;
    r_next.head  = r_next.mem[r_next.rp];
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule

module sadc_host_end #(
  parameter int RES_W     = sadc_pkg::RES_W,
  parameter int DEPTH     = sadc_pkg::FIFO_DEPTH,
  parameter int SCLK_HALF = sadc_pkg::SCLK_HALF
) (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  sadc_link_if.host                 link,
  input  wire logic                 run,
  input  wire logic [1:0]           mode,
  output logic                      res_valid,
  output logic [RES_W-1:0]          res_data,
  input  wire logic                 res_ready,
  output logic                      busy
);

  localparam int DW = $clog2(SCLK_HALF) + 1;
  localparam int CW = 8;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    sadc_pkg::sadc_host_st_t st;
    logic [DW-1:0]           div;
    logic                    sclk;
    logic                    start_lvl;
    logic                    din;
    logic [1:0]              dout_sync;
    logic [CW-1:0]           cnt;
    logic [RES_W-1:0]        shreg;
    logic                    push;
    logic [1:0]              mode_lat;
    logic                    busy;
  } sadc_host_s_t;

  sadc_host_s_t r_reg;
  sadc_host_s_t r_next;
  logic         tick;
  logic         fifo_ready;
  logic         four_wire;

  // one core cycle before sclk rises
  assign tick      = (r_reg.div == DW'(SCLK_HALF - 1)) & ~r_reg.sclk;
  assign four_wire = r_reg.mode_lat == sadc_pkg::SADC_M_4W;

  always_comb begin
    r_next           = r_reg;
    r_next.dout_sync = {r_reg.dout_sync[0], link.dout_line};
    r_next.push      = 1'b0;
    if (r_reg.div == DW'(SCLK_HALF - 1)) begin
      r_next.div  = '0;
      r_next.sclk = ~r_reg.sclk;
    end else begin
      r_next.div = r_reg.div + 1'b1;
    end

    if (tick) begin
      case (r_reg.st)
        sadc_pkg::SADC_H_IDLE: begin
          r_next.start_lvl = 1'b0;
          r_next.mode_lat = mode;
          // mode level set a full tick ahead of the start edge
          r_next.din      = mode != sadc_pkg::SADC_M_DAISY;
          // no start without room for the word, so the FIFO throttles us
          if (run && fifo_ready) begin
            r_next.st = sadc_pkg::SADC_H_ARM;
          end
        end
        sadc_pkg::SADC_H_ARM: begin
          r_next.start_lvl = 1'b1;
          r_next.cnt    = CW'(sadc_pkg::CONV_WAIT_TICKS - 1);
          r_next.st     = sadc_pkg::SADC_H_CONV;
        end
        sadc_pkg::SADC_H_CONV: begin
          // start line stays high through the conversion: no busy bit
          if (r_reg.cnt == '0) begin
            if (four_wire) begin
              r_next.din = 1'b0;
            end else begin
              r_next.start_lvl = 1'b0;
            end
            r_next.cnt = CW'(sadc_pkg::SYNC_LAT - 2);
            r_next.st  = sadc_pkg::SADC_H_LAT;
          end else begin
            r_next.cnt = r_reg.cnt - 1'b1;
          end
        end
        sadc_pkg::SADC_H_LAT: begin
          if (r_reg.cnt == '0) begin
            r_next.cnt = CW'(RES_W - 1);
            r_next.st  = sadc_pkg::SADC_H_READ;
          end else begin
            r_next.cnt = r_reg.cnt - 1'b1;
          end
        end
        sadc_pkg::SADC_H_READ: begin
          // bit taken at the rising edge, before the next fall moves it
          r_next.shreg = {r_reg.shreg[RES_W-2:0], r_reg.dout_sync[1]};
          if (r_reg.cnt == '0) begin
            r_next.push = 1'b1;
            if (four_wire) begin
              r_next.din = 1'b1;
            end
            r_next.cnt = CW'(sadc_pkg::GAP_TICKS - 1);
            r_next.st  = sadc_pkg::SADC_H_GAP;
          end else begin
            r_next.cnt = r_reg.cnt - 1'b1;
          end
        end
        sadc_pkg::SADC_H_GAP: begin
          if (r_reg.cnt == '0) begin
            r_next.st = sadc_pkg::SADC_H_IDLE;
          end else begin
            r_next.cnt = r_reg.cnt - 1'b1;
          end
        end
        default: begin
          r_next.st = sadc_pkg::SADC_H_IDLE;
        end
      endcase
    end
    r_next.busy = r_next.st != sadc_pkg::SADC_H_IDLE;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  sadc_fifo #(
    .W     (RES_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_valid  (r_reg.push),
    .in_ready  (fifo_ready),
    .in_data   (r_reg.shreg),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  assign link.link_clk         = r_reg.sclk;
  assign link.convert_start_in = r_reg.start_lvl;
  assign link.serial_in        = r_reg.din;
  assign busy                  = r_reg.busy;

endmodule
`default_nettype wire

// file: testbench/sadc_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_link_asserts (
  input wire logic link_clk,
  input wire logic link_rstn,
  input wire logic convert_start_in,
  input wire logic serial_in,
  input wire logic dout_oe,
  input wire logic inputs_isolated,
  input wire logic core_active
);
  // ****************************************
  // mode seen at the start edge, fresh-result flag
  // ****************************************
  logic start_d_reg;
  logic cs_reg;
  logic iso_d_reg;
  logic ready_reg;

  // kept here so no property has to look back across a whole conversion
  always_ff @(negedge link_clk) begin
    if (!link_rstn) begin
      start_d_reg <= 1'b0;
      cs_reg      <= 1'b0;
      iso_d_reg   <= 1'b0;
      ready_reg   <= 1'b0;
    end else begin
      start_d_reg <= convert_start_in;
      iso_d_reg   <= inputs_isolated;
      // a fresh result waits unread: only then does a select open the output
      if (dout_oe) begin
        ready_reg <= 1'b0;
      end else if (iso_d_reg && !inputs_isolated) begin
        ready_reg <= 1'b1;
      end
      if (convert_start_in && !start_d_reg) begin
        cs_reg <= serial_in;
      end
    end
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(negedge link_clk); endclocking
  default disable iff (!link_rstn);

  sequence s_conv;
    inputs_isolated [*4] ##1 !inputs_isolated;
  endsequence

  sequence s_deselected;
    (cs_reg && convert_start_in && serial_in) [*4];
  endsequence

  sequence s_word;
    dout_oe [*8] ##1 dout_oe [*8] ##1 !dout_oe;
  endsequence

  start_float_a: assert property ($rose(convert_start_in) |-> ##3 (!dout_oe && inputs_isolated))
    else $error("start edge did not float output and sample");
  conv_length_a: assert property ($rose(inputs_isolated) |-> s_conv)
    else $error("conversion length wrong");
  power_track_a: assert property (inputs_isolated == core_active)
    else $error("core power not tied to conversion");
  quiet_conv_a: assert property (inputs_isolated |-> !dout_oe)
    else $error("output driven during conversion");
  sel_three_a: assert property (ready_reg && cs_reg && serial_in && !inputs_isolated && $fell(convert_start_in)
    |-> ##3 dout_oe)
    else $error("start low did not select output");
  sel_four_a: assert property (cs_reg && convert_start_in && !inputs_isolated && $fell(serial_in)
    |-> ##3 dout_oe)
    else $error("serial input low did not select output");
  deselect_float_a: assert property (s_deselected |-> !dout_oe)
    else $error("output driven while deselected");
  word_length_a: assert property (cs_reg && $rose(dout_oe) |-> s_word)
    else $error("select mode word not sixteen bits");
  daisy_hold_a: assert property (!cs_reg && dout_oe && !convert_start_in && !inputs_isolated |=> dout_oe)
    else $error("daisy output stopped while start low");
endmodule
`default_nettype wire

// file: testbench/test_sar_adc_conversion_serial_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
`define WAIT(cond, lim) begin k = 0; \
  while (((cond) !== 1'b1) && k < lim) begin @(posedge core_clk); #1; k++; end \
  if ((cond) !== 1'b1) begin fails++; $display("CHECK FAILED t=%0t wait timed out", $time); end end
module test_sar_adc_conversion_serial_ctrl;
  typedef struct packed {
    logic [1:0]  mode;
    logic [15:0] pos;
    logic [15:0] neg;
    logic [15:0] res;
  } sadc_row_t;

  localparam int NROWS = 6;
  localparam sadc_row_t ROWS [NROWS] = '{
    '{2'h0, 16'h1234, 16'h0234, 16'h0800},
    '{2'h1, 16'h7fff, 16'h8000, 16'h7fff},
    '{2'h2, 16'h8000, 16'h7fff, 16'h8000},
    '{2'h0, 16'h0000, 16'h0001, 16'hffff},
    '{2'h1, 16'h0005, 16'h0005, 16'h0000},
    '{2'h2, 16'hfff6, 16'h0004, 16'hfff9}
  };

  logic        core_clk;
  logic        rstn;
  logic        link_rstn;
  logic        run;
  logic        res_ready;
  logic [1:0]  mode;
  logic [15:0] pos_in;
  logic [15:0] neg_in;
  logic        res_valid;
  logic        busy;
  logic        inputs_isolated;
  logic        core_active;
  logic [15:0] res_data;
  logic [15:0] last_result;
  logic [15:0] mon_exp;
  logic [15:0] mon_word;
  int          mon_cnt;
  int          fails;
  int          num_checks;
  int          k;

  sadc_link_if sadc_link_if_inst ();

  sadc_host_end sadc_host_end_inst (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .link      (sadc_link_if_inst),
    .run       (run),
    .mode      (mode),
    .res_valid (res_valid),
    .res_data  (res_data),
    .res_ready (res_ready),
    .busy      (busy)
  );

  sadc_dev_end sadc_dev_end_inst (
    .link                  (sadc_link_if_inst),
    .link_rstn             (link_rstn),
    .positive_analog_input (pos_in),
    .negative_analog_input (neg_in),
    .inputs_isolated       (inputs_isolated),
    .core_active           (core_active),
    .last_result           (last_result)
  );

  sadc_link_asserts sadc_link_asserts_inst (
    .link_clk         (sadc_link_if_inst.link_clk),
    .link_rstn        (link_rstn),
    .convert_start_in (sadc_link_if_inst.convert_start_in),
    .serial_in        (sadc_link_if_inst.serial_in),
    .dout_oe          (sadc_link_if_inst.dout_oe),
    .inputs_isolated  (inputs_isolated),
    .core_active      (core_active)
  );

  // ****************************************
  // clock, wire monitor, closing
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // first sixteen driven bits of each frame, msb first
  always @(posedge sadc_link_if_inst.link_clk) begin
    if (sadc_link_if_inst.dout_oe === 1'b1) begin
      if (mon_cnt < 16) begin
        mon_word = {mon_word[14:0], sadc_link_if_inst.dout_line};
        mon_cnt++;
        if (mon_cnt == 16) `CHK(mon_word, mon_exp)
      end
    end else begin
      mon_cnt = 0;
    end
  end

  function automatic logic [15:0] expect_of(input logic [15:0] p, input logic [15:0] n);
    logic [16:0] d;
    d = {p[15], p} - {n[15], n};
    return d[16:1];
  endfunction

  task automatic finish_test;
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic one_conv(input sadc_row_t r);
    mode    = r.mode;
    pos_in  = r.pos;
    neg_in  = r.neg;
    mon_exp = r.res;
    run     = 1'b1;
    `WAIT(busy, 100)
    run = 1'b0;
    `WAIT(res_valid, 2000)
    `CHK(res_data, r.res)
    `CHK(last_result, r.res)
    res_ready = 1'b1;
    @(posedge core_clk);
    #1;
    res_ready = 1'b0;
    `WAIT(!busy, 2000)
  endtask

  // a few thousand core cycles are expected; this leaves ample margin
  initial begin
    #300_000;
    fails++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    finish_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    link_rstn = 1'b0;
    run = 1'b0;
    res_ready = 1'b0;
    mode = 2'h0;
    pos_in = 16'h0000;
    neg_in = 16'h0000;
    mon_exp = 16'h0000;
    mon_word = 16'h0000;
    mon_cnt = 0;
    fails = 0;
    num_checks = 0;
    repeat (5) @(posedge core_clk);
    #1;
    `CHK(res_valid, 1'b0)
    `CHK(busy, 1'b0)
    `CHK(sadc_link_if_inst.link_clk, 1'b0)
    `CHK(sadc_link_if_inst.convert_start_in, 1'b0)
    rstn = 1'b1;
    // device reset is sampled on link falls, so the host clock must run first
    repeat (3) @(negedge sadc_link_if_inst.link_clk);
    @(posedge core_clk);
    #1;
    link_rstn = 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    `CHK(core_active, 1'b0)
    `CHK(last_result, 16'h0000)
    for (int i = 0; i < NROWS; i++) begin
      one_conv(ROWS[i]);
    end

    // input changed once sampling is done must not reach the result
    mode = 2'h0;
    pos_in = 16'h4000;
    neg_in = 16'h0100;
    mon_exp = expect_of(16'h4000, 16'h0100);
    run = 1'b1;
    `WAIT(inputs_isolated, 1000)
    pos_in = 16'h0000;
    run = 1'b0;
    `WAIT(res_valid, 2000)
    `CHK(res_data, expect_of(16'h4000, 16'h0100))
    res_ready = 1'b1;
    @(posedge core_clk);
    #1;
    res_ready = 1'b0;
    `WAIT(!busy, 2000)

    // full buffer stops conversions, then drains all eight words
    pos_in = 16'h0010;
    neg_in = 16'hfff0;
    mon_exp = 16'h0010;
    run = 1'b1;
    for (int i = 0; i < 8; i++) begin
      `WAIT(busy, 1000)
      `WAIT(!busy, 1000)
    end
    repeat (600) @(posedge core_clk);
    #1;
    `CHK(busy, 1'b0)
    run = 1'b0;
    res_ready = 1'b1;
    for (int i = 0; i < 8; i++) begin
      `CHK(res_valid, 1'b1)
      `CHK(res_data, 16'h0010)
      @(posedge core_clk);
      #1;
    end
    res_ready = 1'b0;
    `CHK(res_valid, 1'b0)
    finish_test();
  end
endmodule
`default_nettype wire
